//--- rtl/scal_core.sv
/*
 * Sixteen channel scaler core: counters, cascade, panel controls, bus slave
 * with base address compare, interrupt status/mask.
 * Assumes channel pulses are one-cycle, synchronous to clk, and at most one per
 * cycle per channel; the 25 MHz clk limits the real input rate.
 */
`include "scal_defines.svh"
module scal_core
	import scal_pkg::*;
#(
	parameter int NCH = `SCAL_NCH,
	parameter int NSEC = `SCAL_NSEC,
	parameter int CW = `SCAL_CW
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [NCH-1:0]         ch_pulse,
	input  wire scal_panel_s            panel,
	input  wire logic [NSEC-1:0]        cascade_sel,
	input  wire logic [4*`SCAL_SW_DIGITS-1:0] base_sw,
	input  wire scal_bus_req_s          bus,
	output logic [CW-1:0]               rdata,
	output logic                        dtack,
	output logic                        access_led,
	output logic                        irq
);

	////////////////////////////////////////////////////////////////////////////
	logic [CW-1:0]   cnt_q [NCH];
	logic            bus_set_inhibit_flag_q;
	logic [NSEC-1:0] req_en_q;
	logic            gien_q;
	logic [15:0]     irq_st_q;
	logic [15:0]     irq_msk_q;
	logic [NCH-1:0]  top_prev_q;
	logic [CW-1:0]   rdata_q;
	logic            dtack_q;
	logic            irq_q;
	logic [1:0]      led_cnt_q;
	scal_led_e       led_st_q;

	logic            sel;
	logic [7:0]      off;
	logic            wr_hit;
	logic            rd_hit;
	logic            inhibit;
	logic            clr_all;
	logic            test_inc;
	logic [NCH-1:0]  tick;
	logic [NCH-1:0]  top_now;
	logic [15:0]     ev;

	// Base address: six hex digits give A31..A8; A24 cycles compare A23..A8 only
	function automatic logic base_hit(input logic [`SCAL_AW-1:0] a, input logic am32,
		input logic [4*`SCAL_SW_DIGITS-1:0] sw);
		logic [`SCAL_AW-1:0] b;
		b = {sw, 8'h00};
		if (am32)
			base_hit = ((a ^ b) & `SCAL_A32_MASK) == 32'h0000_0000;
		else
			base_hit = ((a ^ b) & `SCAL_A24_MASK) == 32'h0000_0000;
	endfunction

	function automatic logic is_off(input logic [7:0] o, input logic [7:0] ref_o);
		is_off = (o[7:1] == ref_o[7:1]);
	endfunction

	assign sel    = base_hit(bus.addr, bus.am32, base_sw);
	assign off    = bus.addr[`SCAL_PAGE_BITS-1:0];
	assign wr_hit = sel && bus.wr;
	assign rd_hit = sel && bus.rd;

	// Any access to the clear offset clears, as the write or read strobe may carry it
	assign clr_all  = panel.fast_clear || panel.manual_clear
		|| ((wr_hit || rd_hit) && is_off(off, `SCAL_OFF_CLR));
	assign inhibit  = panel.inhibit || bus_set_inhibit_flag_q;
	// Test increment only in all-split configuration
	assign test_inc = (cascade_sel == '0) && (panel.test
		|| ((wr_hit || rd_hit) && is_off(off, `SCAL_OFF_INCR)));

	////////////////////////////////////////////////////////////////////////////
	// Counters
	genvar s;
	generate
		for (s = 0; s < NSEC; s++) begin : g_sec
			logic carry;
			// Odd channel wrapping to zero is the carry into the even channel
			assign carry = tick[2*s+1] && (cnt_q[2*s+1] == '1);
			assign tick[2*s+1] = ch_pulse[2*s+1] || test_inc;
			assign tick[2*s]   = cascade_sel[s] ? carry
				: (ch_pulse[2*s] || test_inc);
		end
	endgenerate

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			always_ff @(posedge clk) begin
				if (rst || clr_all) begin
					cnt_q[c] <= '0;
				end else if (tick[c] && !inhibit) begin
					cnt_q[c] <= cnt_q[c] + 1'b1;
				end
			end
			// Top bit follows the counter width so a narrowed build still raises events
			assign top_now[c] = cnt_q[c][CW-1];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst)
			top_prev_q <= '0;
		else
			top_prev_q <= top_now;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt sources: rising top bit of each enabled counter
	always_comb begin
		ev = '0;
		for (int i = 0; i < NSEC; i++) begin
			if (req_en_q[i]) begin
				if (cascade_sel[i]) begin
					// Only bit 64 counts: the even channel holds the high word
					ev[2*i] = top_now[2*i] && !top_prev_q[2*i];
				end else begin
					ev[2*i]   = top_now[2*i] && !top_prev_q[2*i];
					ev[2*i+1] = top_now[2*i+1] && !top_prev_q[2*i+1];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || panel.manual_clear) begin
			irq_st_q <= '0;
		end else begin
			// Set wins over a clear in the same cycle
			if (wr_hit && is_off(off, `SCAL_OFF_IRQST))
				irq_st_q <= (irq_st_q & ~bus.wdata[15:0]) | ev;
			else
				irq_st_q <= irq_st_q | ev;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			irq_msk_q <= `SCAL_RST_MSK;
		else if (wr_hit && is_off(off, `SCAL_OFF_IRQMSK))
			irq_msk_q <= bus.wdata[15:0];
	end

	always_ff @(posedge clk) begin
		if (rst)
			req_en_q <= `SCAL_RST_REQEN;
		else if (wr_hit && is_off(off, `SCAL_OFF_REQEN))
			req_en_q <= bus.wdata[NSEC-1:0];
	end

	always_ff @(posedge clk) begin
		if (rst || panel.manual_clear)
			gien_q <= 1'b0;
		else if (wr_hit && is_off(off, `SCAL_OFF_GIEN))
			gien_q <= bus.wdata[0];
	end

	always_ff @(posedge clk) begin
		if (rst || panel.manual_clear)
			irq_q <= 1'b0;
		else
			irq_q <= gien_q && |(irq_st_q & irq_msk_q);
	end

	always_ff @(posedge clk) begin
		if (rst || panel.manual_clear)
			bus_set_inhibit_flag_q <= 1'b0;
		else if ((wr_hit || rd_hit) && is_off(off, `SCAL_OFF_INHSET))
			bus_set_inhibit_flag_q <= 1'b1;
		else if ((wr_hit || rd_hit) && is_off(off, `SCAL_OFF_INHCLR))
			bus_set_inhibit_flag_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port: counters D32 at offset 0x10 + 4*ch; D16 reads pick a half by A1
	always_ff @(posedge clk) begin
		logic [`SCAL_AW-1:0] v;
		logic [3:0]          idx;
		v   = '0;
		idx = 4'(off[5:2] - 4'h4);
		if (rst) begin
			rdata_q <= '0;
		end else if (rd_hit) begin
			if (off >= `SCAL_OFF_CNT0 && off < `SCAL_OFF_CNTEND)
				v = `SCAL_AW'(cnt_q[idx]);
			else if (is_off(off, `SCAL_OFF_STAT))
				v = {16'h0000, inhibit, gien_q, 6'h00, cascade_sel};
			else if (is_off(off, `SCAL_OFF_REQEN))
				v = {24'h000000, req_en_q};
			else if (is_off(off, `SCAL_OFF_GIEN))
				v = {31'h0, gien_q};
			else if (is_off(off, `SCAL_OFF_IRQST))
				v = {16'h0000, irq_st_q};
			else if (is_off(off, `SCAL_OFF_IRQMSK))
				v = {16'h0000, irq_msk_q};
			if (!bus.d32)
				v = {16'h0000, off[1] ? v[15:0] : v[31:16]};
			// Register words are built at full bus width and cut to the port width
			rdata_q <= v[CW-1:0];
		end else begin
			rdata_q <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			dtack_q <= 1'b0;
		else
			dtack_q <= wr_hit || rd_hit;
	end

	// Indicator stretched over a few cycles so a lone access is still visible
	always_ff @(posedge clk) begin
		if (rst) begin
			led_st_q  <= SCAL_IDLE;
			led_cnt_q <= '0;
		end else begin
			case (led_st_q)
				SCAL_IDLE: if (wr_hit || rd_hit) led_st_q <= SCAL_ACK;
				SCAL_ACK: begin
					led_st_q  <= SCAL_SHOW;
					led_cnt_q <= 2'h3;
				end
				SCAL_SHOW: begin
					if (wr_hit || rd_hit)
						led_st_q <= SCAL_ACK;
					else if (led_cnt_q == 2'h0)
						led_st_q <= SCAL_IDLE;
					else
						led_cnt_q <= led_cnt_q - 2'h1;
				end
				default: led_st_q <= SCAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			access_led <= 1'b0;
		else
			access_led <= (led_st_q != SCAL_IDLE);
	end

	assign rdata = rdata_q;
	assign dtack = dtack_q;
	assign irq   = irq_q;

endmodule

//--- rtl/scal_defines.svh
/*
 * Constants of the sixteen channel scaler core: geometry, register offsets,
 * field positions and reset values.
 * Assumes it is included by bare name from the package and the core.
 */
// Notes on behaviour
// - Sixteen independent 32-bit counters, each adds one per pulse on its input.
// - Channel pulses up to 25 MHz, one per clk cycle, are accepted without losing counts.
// - Counters form eight sections of two adjacent channels, configured per section.
// - Each section may join its two channels into one 64-bit cascaded counter.
// - Each section has an enable allowing or suppressing its interrupts.
// - Interrupt raised when enabled and an enabled counter's top bit sets.
// - Front-panel count inhibit input stops all counters while asserted.
// - Front-panel fast clear input zeroes every counter.
// - Test pulse adds one to every counter only when no section cascades.
// - Manual clear zeroes counters, drops interrupt, disables interrupts, clears bus inhibit.
// - Bus slave takes 24 or 32-bit addresses and 16 or 32-bit data.
// - Base address comes from six static rotary switches and is compared.
// - An access indicator pulses each time an access is acknowledged.
// - Cascaded: odd channel counts input 2n+1, even channel counts odd carry.
// - Cascaded value has odd channel low word, even channel high word.
// - Cascaded section interrupts on bit 64; split section on either bit 32.
// - Power-on clears counters, bus inhibit flag, and disables interrupts.
`ifndef SCAL_DEFINES_SVH
`define SCAL_DEFINES_SVH

`define SCAL_NCH        16
`define SCAL_NSEC       8
`define SCAL_CW         32
`define SCAL_MSB        31
`define SCAL_AW         32
`define SCAL_PAGE_BITS  8
`define SCAL_SW_DIGITS  6
`define SCAL_A24_MASK   32'h00FF_FF00
`define SCAL_A32_MASK   32'hFFFF_FF00
// Offsets within the 256-byte page
`define SCAL_OFF_CNT0   8'h10
`define SCAL_OFF_CNTEND 8'h50
`define SCAL_OFF_CLR    8'h50
`define SCAL_OFF_INHSET 8'h52
`define SCAL_OFF_INHCLR 8'h54
`define SCAL_OFF_INCR   8'h56
`define SCAL_OFF_STAT   8'h58
`define SCAL_OFF_REQEN  8'h5C
`define SCAL_OFF_GIEN   8'h60
`define SCAL_OFF_IRQST  8'h64
`define SCAL_OFF_IRQMSK 8'h68
`define SCAL_RST_REQEN  8'h00
`define SCAL_RST_MSK    16'h0000
`define SCAL_MODE_BITS  8

`endif

//--- rtl/scal_pkg.sv
/*
 * Types of the sixteen channel scaler core.
 * Assumes the defines header sits in the include path.
 */
`include "scal_defines.svh"
package scal_pkg;
	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic                 am32;
		logic                 d32;
		logic [`SCAL_AW-1:0]  addr;
		logic [`SCAL_CW-1:0]  wdata;
	} scal_bus_req_s;

	typedef struct packed {
		logic inhibit;
		logic fast_clear;
		logic test;
		logic manual_clear;
	} scal_panel_s;

	typedef enum logic [1:0] {
		SCAL_IDLE = 2'b00,
		SCAL_ACK  = 2'b01,
		SCAL_SHOW = 2'b11
	} scal_led_e;
endpackage

//--- testbench/scal_core_sva.sv
/* Checker for the scaler core: bus answer, access indicator, interrupt.
   Assumes it is bound to scal_core and sees only its ports. */
`include "scal_defines.svh"
module scal_core_sva
	import scal_pkg::*;
#(
	parameter int CW = `SCAL_CW
) (
	input wire logic                          clk,
	input wire logic                          rst,
	input wire scal_panel_s                   panel,
	input wire logic [4*`SCAL_SW_DIGITS-1:0]  base_sw,
	input wire scal_bus_req_s                 bus,
	input wire logic [CW-1:0]                 rdata,
	input wire logic                          dtack,
	input wire logic                          access_led,
	input wire logic                          irq
);
	logic hit;
	assign hit = (bus.wr | bus.rd) & (bus.am32 ? bus.addr[31:8] == base_sw
		: bus.addr[23:8] == base_sw[15:0]);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	chk_hit_acked: assert property (hit |=> dtack)
		else $error("no dtack after a hit");
	chk_foreign_quiet: assert property (!hit |=> !dtack)
		else $error("dtack without a hit");
	chk_rdata_idle: assert property (!(bus.rd & hit) |=> rdata == '0)
		else $error("read data outside a read answer");
	chk_led_after: assert property (dtack |=> access_led)
		else $error("indicator not lit after dtack");
	chk_led_dark: assert property (!dtack [*8] |=> !access_led)
		else $error("indicator lit without access");
	chk_irq_manclr: assert property (panel.manual_clear |-> ##2 !irq)
		else $error("irq kept after manual clear");
	chk_irq_gien_off: assert property (bus.wr & hit & bus.addr[7:1] == 7'h30
		& !bus.wdata[0] |-> ##2 !irq)
		else $error("irq kept with interrupts disabled");
	chk_rst_quiet: assert property ($fell(rst) |-> !irq & !dtack & !access_led)
		else $error("outputs active after reset");
endmodule
bind scal_core scal_core_sva #(.CW(CW)) scal_core_sva_i (.clk(clk), .rst(rst),
	.panel(panel), .base_sw(base_sw), .bus(bus), .rdata(rdata), .dtack(dtack),
	.access_led(access_led), .irq(irq));

//--- testbench/scal_host.sv
/* Host model: single-cycle read and write strobes toward the core.
   Assumes dtack and read data stand in the cycle after the strobe. */
module scal_host
	import scal_pkg::*;
#(
	parameter int CW = 32
) (
	input wire logic           clk,
	input wire logic           dtack,
	input wire logic [CW-1:0]  rdata,
	output scal_bus_req_s      bus
);
	initial bus = '0;
	task automatic acc(input logic w, input logic m, input logic [31:0] a,
		input logic [31:0] d, output logic ack, output logic [CW-1:0] q);
		@(posedge clk);
		bus <= '{wr: w, rd: !w, am32: m, d32: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		// Released lines show the inverse so stale values cannot pass
		bus <= '{wr: 1'b0, rd: 1'b0, am32: m, d32: 1'b1, addr: ~a, wdata: ~d};
		#1;
		ack = dtack;
		q = rdata;
	endtask
endmodule

//--- testbench/sixteen_channel_scaler_core_tb.sv
/* Testbench of the scaler core: counting, inhibit, test, clear, cascade, irq.
   Assumes a 16-bit counter width so wrap and top-bit events fit the run. */
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s: expected %h seen %h", n, e, g); end end
module sixteen_channel_scaler_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scal_pkg::*;
	localparam int CW = 16;
	localparam logic [23:0] BASE = 24'h12_3456;
	logic           clk = 1'b0;
	logic           rst = 1'b1;
	logic [15:0]    ch_pulse = '0;
	scal_panel_s    panel = '0;
	logic [7:0]     casc = '0;
	scal_bus_req_s  bus;
	logic [CW-1:0]  rdata, q;
	logic           dtack, led, irq, ack;
	int             err_total = 0;
	int             checks_done = 0;
	always #20 clk = ~clk;
	scal_core #(.CW(CW)) scal_core_i (.clk(clk), .rst(rst), .ch_pulse(ch_pulse),
		.panel(panel), .cascade_sel(casc), .base_sw(BASE), .bus(bus), .rdata(rdata),
		.dtack(dtack), .access_led(led), .irq(irq));
	scal_host #(.CW(CW)) scal_host_i (.clk(clk), .dtack(dtack), .rdata(rdata), .bus(bus));
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		scal_host_i.acc(1'b1, 1'b1, {BASE, off}, d, ack, q);
		`CHK("write ack", 1'b1, ack)
	endtask
	task automatic rd(input int ch, input logic [CW-1:0] e);
		scal_host_i.acc(1'b0, 1'b1, {BASE, 8'h10 + 8'(4 * ch)}, '0, ack, q);
		`CHK("counter", e, q)
	endtask
	task automatic pulse(input logic [15:0] m, input int n);
		repeat (n) begin
			@(posedge clk);
			ch_pulse <= m;
		end
		@(posedge clk);
		ch_pulse <= '0;
	endtask
	task automatic pan(input scal_panel_s p);
		@(posedge clk);
		panel <= p;
		@(posedge clk);
		panel <= '0;
	endtask
	task automatic seeirq(input logic e);
		repeat (2) @(posedge clk);
		#1;
		`CHK("irq", e, irq)
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(0, 16'h0000);
		for (int i = 0; i < 16; i++) pulse(16'h0001 << i, i + 1);
		for (int i = 0; i < 16; i++) rd(i, CW'(i + 1));
		scal_host_i.acc(1'b0, 1'b0, {8'h00, BASE[15:0], 8'h14}, '0, ack, q);
		`CHK("short address read", 16'h0002, q)
		scal_host_i.acc(1'b0, 1'b1, {~BASE, 8'h10}, '0, ack, q);
		`CHK("foreign ack", 1'b0, ack)
		panel.inhibit <= 1'b1;
		pulse(16'h0001, 3);
		panel.inhibit <= 1'b0;
		rd(0, 16'h0001);
		wr(8'h52, '0);
		pulse(16'h0001, 3);
		rd(0, 16'h0001);
		wr(8'h54, '0);
		pulse(16'h0001, 3);
		rd(0, 16'h0004);
		pan(4'b0010);
		wr(8'h56, '0);
		rd(0, 16'h0006);
		rd(15, 16'h0012);
		casc <= 8'h02;
		pan(4'b0010);
		rd(0, 16'h0006);
		pan(4'b0100);
		rd(5, 16'h0000);
		wr(8'h60, 32'h0000_0001);
		wr(8'h5C, 32'h0000_00FF);
		wr(8'h68, 32'h0000_FFFF);
		// Top bit sets on every split channel; the cascaded low word gives no event
		pulse(16'hFFFF, 32768);
		seeirq(1'b1);
		wr(8'h68, 32'h0000_0000);
		seeirq(1'b0);
		wr(8'h68, 32'h0000_FFFF);
		seeirq(1'b1);
		wr(8'h64, 32'h0000_FFFF);
		seeirq(1'b0);
		pulse(16'hFFFF, 32768);
		rd(0, 16'h0000);
		rd(3, 16'h0000);
		rd(2, 16'h0001);
		wr(8'h52, '0);
		pan(4'b0001);
		rd(2, 16'h0000);
		pulse(16'h0001, 1);
		rd(0, 16'h0001);
		wr(8'h60, 32'h0000_0000);
		summarize();
	end
	initial begin
		repeat (80000) @(posedge clk);
		err_total++;
		summarize();
	end
endmodule
